// ---- logic/tfg_pkg.sv ----
// Shared constants, types and register layouts for the extended-page control block
package tfg_pkg;

  // Register indices (5-bit management index space)
  localparam logic [4:0] IDX_STD_LAST     = 5'h0_f;
  localparam logic [4:0] IDX_EXT_FIRST    = 5'h1_0;
  localparam logic [4:0] IDX_EXT_LAST     = 5'h1_e;
  localparam logic [4:0] IDX_GEN_CONTROL  = 5'h1_d;
  localparam logic [4:0] IDX_GEN_PATTERN  = 5'h1_e;
  localparam logic [4:0] IDX_AMP_TRIM     = 5'h1_0;
  localparam logic [4:0] IDX_ENERGY_CTRL  = 5'h1_1;
  localparam logic [4:0] IDX_PAGE_ACCESS  = 5'h1_f;

  // Page access values
  localparam logic [15:0] PAGE_MAIN       = 16'h0000;
  localparam logic [15:0] PAGE_SECOND     = 16'h0002;

  // Generator control field positions
  localparam int GEN_ENABLE_BIT           = 15;
  localparam int GEN_RUN_BIT              = 14;
  localparam int GEN_CONT_BIT             = 13;
  localparam int GEN_LEN_HI               = 12;
  localparam int GEN_LEN_LO               = 11;
  localparam int GEN_GAP_BIT              = 10;
  localparam int GEN_DST_HI               = 9;
  localparam int GEN_DST_LO               = 6;
  localparam int GEN_SRC_HI               = 5;
  localparam int GEN_SRC_LO               = 2;
  localparam int GEN_RANDOM_BIT           = 1;
  localparam int GEN_BADFCS_BIT           = 0;

  // Energy control field positions
  localparam int EN_10TE_BIT              = 15;
  localparam int EN_LED_HI                = 13;
  localparam int EN_LED_LO                = 10;
  localparam int EN_LINK_BIT              = 8;
  localparam int EN_GIG_STAT_BIT          = 7;
  localparam int EN_FAST_STAT_BIT         = 6;
  localparam int EN_FORCE_GIG_BIT         = 5;
  localparam int EN_FORCE_LPI_BIT         = 4;
  localparam int EN_INH_TX_FAST_BIT       = 3;
  localparam int EN_INH_RX_FAST_BIT       = 2;
  localparam int EN_INH_TX_GIG_BIT        = 1;
  localparam int EN_INH_RX_GIG_BIT        = 0;
  localparam logic [15:0] ENERGY_WR_MASK  = 16'hbc3f;

  // Reset values
  localparam logic [15:0] GEN_CONTROL_RST = 16'h0040;
  localparam logic [15:0] GEN_PATTERN_RST = 16'h0000;
  localparam logic [15:0] AMP_TRIM_RST    = 16'h02de;
  localparam logic [15:0] ENERGY_RST      = 16'h0000;

  // Frame lengths in bytes, including the check sequence
  localparam logic [13:0] LEN_125         = 14'h007d;
  localparam logic [13:0] LEN_64          = 14'h0040;
  localparam logic [13:0] LEN_1518        = 14'h05ee;
  localparam logic [13:0] LEN_JUMBO       = 14'h2710;

  // Gaps in bit times, turned into byte slots
  localparam int GAP_SHORT_BITS           = 96;
  localparam int GAP_LONG_BITS            = 8192;
  localparam logic [10:0] GAP_SHORT_BYTES = 11'(GAP_SHORT_BITS / 8);
  localparam logic [10:0] GAP_LONG_BYTES  = 11'(GAP_LONG_BITS / 8);

  // Burst sizes and the stop granule
  localparam logic [24:0] BURST_GIG       = 25'h1c9_c380;
  localparam logic [24:0] BURST_FAST      = 25'h02d_c6c0;
  localparam logic [24:0] BURST_SLOW      = 25'h004_93e0;
  localparam logic [13:0] STOP_GRANULE    = 14'h2710;

  // Line speed codes
  localparam logic [1:0] SPD_10           = 2'h0;
  localparam logic [1:0] SPD_100          = 2'h1;
  localparam logic [1:0] SPD_1000         = 2'h2;

  // Management request
  typedef struct packed {
    logic [4:0]  idx;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tfg_req_s;

  // Byte stream toward the line
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } tfg_byte_s;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_BODY, ST_FCS, ST_GAP, ST_DONE} tfg_state_e;

endpackage

// ---- logic/tfg_ext_page_ctrl.sv ----
// Extended-page register bank, test frame generator and energy-saving controls
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

// Contract
// - Stop waits for a multiple of 10,000
// - Burst count by speed, or continuous
// - Length field picks the frame size
// - Gap bit picks 96 or 8192 bits
// - Addresses all F except lowest nibble
// - Payload fixed or random
// - Bad-checksum bit corrupts the FCS
// - Fixed payload repeats the pattern register
// - Page two remaps indices 16 to 30
// - Indices 0 to 15 ignore the page
// - Writing 0000h restores the main page
// - Page access at 31; reserved read zero
// - Bit 15 enables 10BASE-Te mode
// - LED polarity per bit, reset zero
// - Bit 8 shows live link state
// - Bits 7,6 show energy-saving resolution
// - Bit 5 with speed 10b forces gigabit
// - Bit 4 forces LPI toward the line
// - Transmit inhibits block LPI to line
// - Receive inhibits block LPI to MAC
// - Four trim fields with given resets
module tfg_ext_page_ctrl (
  input  wire logic               i_mclk,
  input  wire logic               i_sys_rst,
  input  wire tfg_pkg::tfg_req_s  i_req,
  output logic [15:0]             o_rdata,
  output logic                    o_std_sel,
  output logic [15:0]             o_std_wdata,
  input  wire logic [15:0]        i_std_rdata,
  input  wire logic [1:0]         i_speed,
  input  wire logic [1:0]         i_mode_speed_sel,
  input  wire logic               i_link_up,
  input  wire logic               i_an_gig_eee,
  input  wire logic               i_an_fast_eee,
  input  wire tfg_pkg::tfg_byte_s i_mac_tx,
  input  wire logic               i_mac_tx_lpi,
  input  wire logic               i_line_rx_lpi,
  input  wire logic [3:0]         i_led_state,
  output tfg_pkg::tfg_byte_s      o_line_tx,
  output logic                    o_line_tx_lpi,
  output logic                    o_mac_rx_lpi,
  output logic [3:0]              o_indicator_outputs,
  output logic                    o_force_gig,
  output logic                    o_mode_10te,
  output logic [15:0]             o_amp_trim,
  output logic                    o_gen_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for link status inputs
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  wire  [3:0] pins_raw = {i_link_up, i_an_gig_eee, i_an_fast_eee, i_line_rx_lpi};

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  wire link_up_s  = sync_b[3];
  wire gig_eee_s  = sync_b[2];
  wire fast_eee_s = sync_b[1];
  wire rx_lpi_s   = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and address decode
  logic [15:0] page_access;
  logic [15:0] gen_ctrl;
  logic [15:0] gen_pattern;
  logic [15:0] amp_trim;
  logic [15:0] energy_ctrl;

  wire on_second  = (page_access == tfg_pkg::PAGE_SECOND);
  wire idx_std    = (i_req.idx <= tfg_pkg::IDX_STD_LAST);
  wire idx_page   = (i_req.idx == tfg_pkg::IDX_PAGE_ACCESS);
  wire sel_ctrl   = !on_second && (i_req.idx == tfg_pkg::IDX_GEN_CONTROL);
  wire sel_pat    = !on_second && (i_req.idx == tfg_pkg::IDX_GEN_PATTERN);
  wire sel_trim   = on_second && (i_req.idx == tfg_pkg::IDX_AMP_TRIM);
  wire sel_energy = on_second && (i_req.idx == tfg_pkg::IDX_ENERGY_CTRL);

  // Standard indices pass straight through to the shared register set
  assign o_std_sel   = idx_std && (i_req.wr || i_req.rd);
  assign o_std_wdata = i_req.wdata;

  // Live status bits merged into the energy register read value
  wire [15:0] energy_rd = (energy_ctrl & tfg_pkg::ENERGY_WR_MASK)
                        | (16'(link_up_s)  << tfg_pkg::EN_LINK_BIT)
                        | (16'(gig_eee_s)  << tfg_pkg::EN_GIG_STAT_BIT)
                        | (16'(fast_eee_s) << tfg_pkg::EN_FAST_STAT_BIT);

  // Read mux; reserved and unmapped indices read zero
  wire [15:0] rd_mux = idx_std    ? i_std_rdata :
                       idx_page   ? page_access :
                       sel_ctrl   ? gen_ctrl :
                       sel_pat    ? gen_pattern :
                       sel_trim   ? amp_trim :
                       sel_energy ? energy_rd : 16'h0000;

  // Register writes; page register takes any value, only 0002h selects page two
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      page_access <= tfg_pkg::PAGE_MAIN;
      gen_ctrl    <= tfg_pkg::GEN_CONTROL_RST;
      gen_pattern <= tfg_pkg::GEN_PATTERN_RST;
      amp_trim    <= tfg_pkg::AMP_TRIM_RST;
      energy_ctrl <= tfg_pkg::ENERGY_RST;
      o_rdata     <= 16'h0000;
    end
    else
    begin
      if (i_req.wr && idx_page) page_access <= i_req.wdata;
      if (i_req.wr && sel_ctrl) gen_ctrl <= i_req.wdata;
      if (i_req.wr && sel_pat) gen_pattern <= i_req.wdata;
      if (i_req.wr && sel_trim) amp_trim <= i_req.wdata;
      if (i_req.wr && sel_energy) energy_ctrl <= i_req.wdata & tfg_pkg::ENERGY_WR_MASK;
      o_rdata <= i_req.rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy-saving and LED outputs
  assign o_mode_10te   = energy_ctrl[tfg_pkg::EN_10TE_BIT];
  assign o_force_gig   = energy_ctrl[tfg_pkg::EN_FORCE_GIG_BIT]
                       && (i_mode_speed_sel == tfg_pkg::SPD_1000);
  assign o_amp_trim    = amp_trim;

  wire inh_tx = (i_speed == tfg_pkg::SPD_1000) ? energy_ctrl[tfg_pkg::EN_INH_TX_GIG_BIT] :
                (i_speed == tfg_pkg::SPD_100)  ? energy_ctrl[tfg_pkg::EN_INH_TX_FAST_BIT] :
                1'b0;
  wire inh_rx = (i_speed == tfg_pkg::SPD_1000) ? energy_ctrl[tfg_pkg::EN_INH_RX_GIG_BIT] :
                (i_speed == tfg_pkg::SPD_100)  ? energy_ctrl[tfg_pkg::EN_INH_RX_FAST_BIT] :
                1'b0;
  // Forced LPI replaces idles only; MAC frames still win while present
  wire force_lpi = energy_ctrl[tfg_pkg::EN_FORCE_LPI_BIT] && !i_mac_tx.valid;

  assign o_line_tx_lpi = force_lpi || (i_mac_tx_lpi && !inh_tx);
  assign o_mac_rx_lpi  = rx_lpi_s && !inh_rx;

  // Polarity per indicator; zero gives an active-low drive
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_led
      assign o_indicator_outputs[g] =
        energy_ctrl[tfg_pkg::EN_LED_LO + g] ? i_led_state[g] : !i_led_state[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Test frame generator
  wire        gen_en   = gen_ctrl[tfg_pkg::GEN_ENABLE_BIT];
  wire        gen_run  = gen_ctrl[tfg_pkg::GEN_RUN_BIT];
  wire [1:0]  len_code = gen_ctrl[tfg_pkg::GEN_LEN_HI:tfg_pkg::GEN_LEN_LO];
  wire [3:0]  dst_nib  = gen_ctrl[tfg_pkg::GEN_DST_HI:tfg_pkg::GEN_DST_LO];
  wire [3:0]  src_nib  = gen_ctrl[tfg_pkg::GEN_SRC_HI:tfg_pkg::GEN_SRC_LO];

  wire [13:0] frame_len = (len_code == 2'h0) ? tfg_pkg::LEN_125 :
                          (len_code == 2'h1) ? tfg_pkg::LEN_64 :
                          (len_code == 2'h2) ? tfg_pkg::LEN_1518 :
                          tfg_pkg::LEN_JUMBO;
  wire [10:0] gap_len   = gen_ctrl[tfg_pkg::GEN_GAP_BIT] ?
                          tfg_pkg::GAP_LONG_BYTES : tfg_pkg::GAP_SHORT_BYTES;
  wire [24:0] burst_len = (i_speed == tfg_pkg::SPD_1000) ? tfg_pkg::BURST_GIG :
                          (i_speed == tfg_pkg::SPD_100)  ? tfg_pkg::BURST_FAST :
                          tfg_pkg::BURST_SLOW;

  tfg_pkg::tfg_state_e state;
  tfg_pkg::tfg_state_e next_state;
  logic [13:0] byte_cnt;
  logic [24:0] pkt_cnt;
  logic [13:0] gran_cnt;
  logic [10:0] gap_cnt;
  logic [31:0] crc;
  logic [15:0] lfsr;
  logic        stopping;

  // Header bytes: destination, source, then length/type field
  wire [7:0] hdr_byte = (byte_cnt == 14'd5)  ? {4'hf, dst_nib} :
                        (byte_cnt < 14'd5)   ? 8'hff :
                        (byte_cnt == 14'd11) ? {4'hf, src_nib} :
                        (byte_cnt < 14'd11)  ? 8'hff : 8'h00;
  wire [7:0] body_byte = gen_ctrl[tfg_pkg::GEN_RANDOM_BIT] ? lfsr[7:0] :
                         (byte_cnt[0] ? gen_pattern[7:0] : gen_pattern[15:8]);
  wire [13:0] fcs_start = frame_len - 14'd4;
  wire [1:0]  fcs_idx   = 2'(byte_cnt - fcs_start);
  wire [31:0] fcs_val   = gen_ctrl[tfg_pkg::GEN_BADFCS_BIT] ? crc : ~crc;
  wire [7:0]  fcs_byte  = fcs_val[8 * fcs_idx +: 8];
  wire [7:0]  cur_byte  = (state == tfg_pkg::ST_HDR)  ? hdr_byte :
                          (state == tfg_pkg::ST_BODY) ? body_byte : fcs_byte;
  wire        sending   = (state == tfg_pkg::ST_HDR) || (state == tfg_pkg::ST_BODY)
                          || (state == tfg_pkg::ST_FCS);
  wire        frame_end = (state == tfg_pkg::ST_FCS) && (fcs_idx == 2'h3);
  wire        gap_end   = (state == tfg_pkg::ST_GAP) && (gap_cnt == gap_len - 11'd1);
  wire        burst_hit = !gen_ctrl[tfg_pkg::GEN_CONT_BIT] && (pkt_cnt == burst_len);
  wire        gran_hit  = (gran_cnt == 14'd0);

  // CRC-32 over one byte, reflected polynomial
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int k = 0; k < 8; k++)
      r = r[0] ? ((r >> 1) ^ 32'hedb8_8320) : (r >> 1);
    return r;
  endfunction

  // Next-state selection
  always_comb
  begin
    next_state = state;
    case (state)
      tfg_pkg::ST_IDLE: if (gen_en && gen_run) next_state = tfg_pkg::ST_HDR;
      tfg_pkg::ST_HDR:  if (byte_cnt == 14'd13) next_state = tfg_pkg::ST_BODY;
      tfg_pkg::ST_BODY: if (byte_cnt == fcs_start - 14'd1) next_state = tfg_pkg::ST_FCS;
      tfg_pkg::ST_FCS:  if (frame_end) next_state = tfg_pkg::ST_GAP;
      tfg_pkg::ST_GAP:
        if (gap_end)
        begin
          if (!gen_en) next_state = tfg_pkg::ST_IDLE;
          else if (burst_hit) next_state = tfg_pkg::ST_DONE;
          else if (stopping && gran_hit) next_state = tfg_pkg::ST_IDLE;
          else next_state = tfg_pkg::ST_HDR;
        end
      tfg_pkg::ST_DONE: if (!gen_run || !gen_en) next_state = tfg_pkg::ST_IDLE;
      default: next_state = tfg_pkg::ST_IDLE;
    endcase
  end

  // Generator datapath; packet counts restart with every fresh run
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state    <= tfg_pkg::ST_IDLE;
      byte_cnt <= 14'd0;
      pkt_cnt  <= 25'd0;
      gran_cnt <= 14'd0;
      gap_cnt  <= 11'd0;
      crc      <= 32'hffff_ffff;
      lfsr     <= 16'hace1;
      stopping <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      lfsr     <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      stopping <= (state != tfg_pkg::ST_IDLE) && (stopping || !gen_run);
      byte_cnt <= (sending && !frame_end) ? byte_cnt + 14'd1 : 14'd0;
      gap_cnt  <= (state == tfg_pkg::ST_GAP) ? gap_cnt + 11'd1 : 11'd0;
      if (state == tfg_pkg::ST_IDLE)
      begin
        pkt_cnt  <= 25'd0;
        gran_cnt <= 14'd0;
      end
      else if (frame_end)
      begin
        pkt_cnt  <= pkt_cnt + 25'd1;
        gran_cnt <= (gran_cnt == tfg_pkg::STOP_GRANULE - 14'd1) ? 14'd0 : gran_cnt + 14'd1;
      end
      if (state == tfg_pkg::ST_HDR || state == tfg_pkg::ST_BODY)
        crc <= crc_step(crc, cur_byte);
      else if (!sending)
        crc <= 32'hffff_ffff;
    end
  end

  // Line transmit: generator owns the line only while enabled
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_line_tx <= '0;
    else if (gen_en)
      o_line_tx <= '{valid: sending, data: sending ? cur_byte : 8'h00, last: frame_end};
    else
      o_line_tx <= i_mac_tx;
  end

  assign o_gen_busy = (state != tfg_pkg::ST_IDLE) && (state != tfg_pkg::ST_DONE);

endmodule // tfg_ext_page_ctrl

// ---- test/tfg_ext_page_monitor.sv ----
// Port-level assertions for the extended-page control block
`timescale 1ns/10ps
module tfg_ext_page_monitor (
  input  wire logic               i_mclk,
  input  wire logic               i_sys_rst,
  input  wire tfg_pkg::tfg_req_s  i_req,
  input  wire logic [15:0]        o_rdata,
  input  wire logic [15:0]        i_std_rdata,
  input  wire logic [1:0]         i_mode_speed_sel,
  input  wire logic               i_line_rx_lpi,
  input  wire logic [3:0]         i_led_state,
  input  wire tfg_pkg::tfg_byte_s o_line_tx,
  input  wire logic               o_mac_rx_lpi,
  input  wire logic [3:0]         o_indicator_outputs,
  input  wire logic               o_force_gig,
  input  wire logic [15:0]        o_amp_trim,
  input  wire logic               o_gen_busy
);
  logic [3:0] led_pol;
  default clocking mon_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // Pin level against raw state isolates the inverted polarity bits
  assign led_pol = o_indicator_outputs ^ i_led_state;
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  chk_idle_rdata_zero : assert property (!i_req.rd |=> o_rdata == 16'h0000)
    else $error("Read data outside its slot");
  chk_std_read_pass : assert property (i_req.rd && i_req.idx <= 5'h0f |=>
    o_rdata == $past(i_std_rdata)) else $error("Standard read not passed through");
  chk_page_readback : assert property (i_req.wr && i_req.idx == 5'h1f ##1 !i_req.wr
    ##1 i_req.rd && i_req.idx == 5'h1f |=> o_rdata == $past(i_req.wdata, 3))
    else $error("Page access read back wrong");
  chk_led_pol_hold : assert property (!i_req.wr |=> $stable(led_pol))
    else $error("Indicator polarity moved without a write");
  chk_trim_hold : assert property (!i_req.wr |=> $stable(o_amp_trim))
    else $error("Trim changed without a write");
  // Line side
  chk_force_gig_sel : assert property (o_force_gig |-> i_mode_speed_sel == 2'b10)
    else $error("Gigabit force without speed select 10b");
  chk_gap_after_frame : assert property (o_line_tx.valid && o_line_tx.last && o_gen_busy
    |=> (!o_line_tx.valid) [*8]) else $error("Gap after frame too short");
  chk_frame_head : assert property ($rose(o_line_tx.valid) && o_gen_busy |->
    (o_line_tx.data == 8'hff) [*5]) else $error("Address head not all ones");
  chk_rx_lpi_cause : assert property (o_mac_rx_lpi |->
    $past(i_line_rx_lpi, 2) || $past(i_line_rx_lpi, 3)) else $error("Receive LPI uncaused");
  cov_gen_start : cover property ($rose(o_gen_busy));
  cov_force_gig : cover property (o_force_gig);
  cov_rx_lpi : cover property (o_mac_rx_lpi);
endmodule // tfg_ext_page_monitor

bind tfg_ext_page_ctrl tfg_ext_page_monitor u_mon (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rdata(o_rdata),
  .i_std_rdata(i_std_rdata), .i_mode_speed_sel(i_mode_speed_sel),
  .i_line_rx_lpi(i_line_rx_lpi), .i_led_state(i_led_state), .o_line_tx(o_line_tx),
  .o_mac_rx_lpi(o_mac_rx_lpi), .o_indicator_outputs(o_indicator_outputs),
  .o_force_gig(o_force_gig), .o_amp_trim(o_amp_trim), .o_gen_busy(o_gen_busy)
);

// ---- test/tfg_link_partner.sv ----
// Cable partner model: collects line frames and drives link status levels
`timescale 1ns/10ps
module tfg_link_partner (
  input  wire logic               i_mclk,
  input  wire tfg_pkg::tfg_byte_s i_line,
  output logic                    o_link_up,
  output logic                    o_gig_eee,
  output logic                    o_fast_eee,
  output logic                    o_rx_lpi
);
  logic [7:0] frame [0:10015];
  int         rx_len = 0;
  int         last_len = 0;
  int         gap = 0;
  int         last_gap = 0;
  int         frames = 0;
  // Status stays down until the bench raises it
  initial
  begin
    o_link_up = 1'b0;
    o_gig_eee = 1'b0;
    o_fast_eee = 1'b0;
    o_rx_lpi = 1'b0;
  end
  // One byte a clock; an idle slot drops a partial frame, since a reset may cut one short
  always @(posedge i_mclk)
  begin
    if (i_line.valid)
    begin
      if (rx_len == 0)
        last_gap = gap;
      gap = 0;
      if (rx_len < 10016)
        frame[rx_len] = i_line.data;
      rx_len++;
      if (i_line.last)
      begin
        last_len = rx_len;
        frames++;
        rx_len = 0;
      end
    end
    else
    begin
      rx_len = 0;
      gap++;
    end
  end
endmodule // tfg_link_partner

// ---- test/tfg_ext_page_ctrl_bench.sv ----
// Self-checking bench for the extended-page control block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tfg_ext_page_ctrl_bench;
  logic               clk, rst, std_sel, link, gig_eee, fast_eee, rx_in, mac_lpi;
  logic               tx_lpi, rx_lpi, force_gig, mode_10te, busy;
  logic [15:0]        rdata, std_wdata, std_rdata, amp;
  logic [1:0]         speed, mode_sel;
  logic [3:0]         led, ind;
  tfg_pkg::tfg_req_s  req;
  tfg_pkg::tfg_byte_s mac_tx, line_tx;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  logic [15:0]        lpi_tab [8] = '{16'h00b8, 16'h02a8, 16'h0868, 16'h08b8,
                                      16'h0180, 16'h0440, 16'h0488, 16'h1098};
  logic [13:0]        len_tab [4] = '{tfg_pkg::LEN_125, tfg_pkg::LEN_64,
                                      tfg_pkg::LEN_1518, tfg_pkg::LEN_JUMBO};
  tfg_ext_page_ctrl DUT (.i_mclk(clk), .i_sys_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_std_sel(std_sel), .o_std_wdata(std_wdata), .i_std_rdata(std_rdata), .i_speed(speed),
    .i_mode_speed_sel(mode_sel), .i_link_up(link), .i_an_gig_eee(gig_eee),
    .i_an_fast_eee(fast_eee), .i_mac_tx(mac_tx), .i_mac_tx_lpi(mac_lpi),
    .i_line_rx_lpi(rx_in), .i_led_state(led), .o_line_tx(line_tx), .o_line_tx_lpi(tx_lpi),
    .o_mac_rx_lpi(rx_lpi), .o_indicator_outputs(ind), .o_force_gig(force_gig),
    .o_mode_10te(mode_10te), .o_amp_trim(amp), .o_gen_busy(busy));
  tfg_link_partner lp (.i_mclk(clk), .i_line(line_tx), .o_link_up(link),
    .o_gig_eee(gig_eee), .o_fast_eee(fast_eee), .o_rx_lpi(rx_in));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and a cycle ceiling far above the expected run
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks: one strobe cycle, then an idle slot so no signal is assigned twice at once
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    req <= '{idx: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    req <= '{idx: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 `CHK(rdata, exp)
    @(posedge clk);
  endtask
  // Fresh generator run: reset clears any pending stop, then wait for two whole frames
  task automatic gen_run(input logic [15:0] ctl);
    int n0;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(tfg_pkg::IDX_GEN_PATTERN, 16'h5a5a);
    n0 = lp.frames;
    wr(tfg_pkg::IDX_GEN_CONTROL, ctl);
    for (int k = 0; k < 24000 && lp.frames < n0 + 2; k++)
      @(posedge clk);
  endtask
  // Reference CRC-32 over the first n captured bytes, before the final inversion
  function automatic logic [31:0] frame_crc(input int n);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ {24'h00_0000, lp.frame[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
    end
    return c;
  endfunction
  // Check sequence of an n-byte frame, low byte sent first
  function automatic logic [31:0] fcs_at(input int n);
    return {lp.frame[n - 1], lp.frame[n - 2], lp.frame[n - 3], lp.frame[n - 4]};
  endfunction
  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int          n;
    rst = 1'b1;
    req = '0;
    std_rdata = 16'h1234;
    speed = 2'h2;
    mode_sel = 2'h2;
    mac_tx = '0;
    mac_lpi = 1'b0;
    led = 4'h5;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and the page map
    rc(tfg_pkg::IDX_GEN_CONTROL, 16'h0040);
    rc(tfg_pkg::IDX_GEN_PATTERN, 16'h0000);
    rc(5'h03, 16'h1234);
    `CHK(ind, ~led)
    wr(tfg_pkg::IDX_PAGE_ACCESS, tfg_pkg::PAGE_SECOND);
    rc(tfg_pkg::IDX_PAGE_ACCESS, 16'h0002);
    rc(tfg_pkg::IDX_AMP_TRIM, 16'h02de);
    rc(tfg_pkg::IDX_ENERGY_CTRL, 16'h0000);
    rc(5'h12, 16'h0000);
    rc(5'h1e, 16'h0000);
    rc(tfg_pkg::IDX_GEN_CONTROL, 16'h0000);
    rc(5'h03, 16'h1234);
    // Standard write still forwarded while page two is selected
    req <= '{idx: 5'h04, wdata: 16'hbeef, wr: 1'b1, rd: 1'b0};
    #1 `CHK({std_sel, std_wdata}, 17'h1_beef)
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    wr(tfg_pkg::IDX_ENERGY_CTRL, 16'hffff);
    rc(tfg_pkg::IDX_ENERGY_CTRL, 16'hbc3f);
    `CHK({mode_10te, force_gig, ind}, {2'b11, led})
    mode_sel <= 2'h1;
    @(posedge clk);
    #1 `CHK(force_gig, 1'b0)
    mode_sel <= 2'h2;
    lp.o_link_up <= 1'b1;
    lp.o_gig_eee <= 1'b1;
    repeat (4) @(posedge clk);
    rc(tfg_pkg::IDX_ENERGY_CTRL, 16'hbdbf);
    wr(tfg_pkg::IDX_AMP_TRIM, 16'ha5c3);
    rc(tfg_pkg::IDX_AMP_TRIM, 16'ha5c3);
    `CHK(amp, 16'ha5c3)
    // Low-power idle: forcing and per-mode inhibits, line LPI arriving throughout
    lp.o_rx_lpi <= 1'b1;
    foreach (lpi_tab[i])
    begin
      speed <= lpi_tab[i][7:6];
      mac_lpi <= lpi_tab[i][5];
      wr(tfg_pkg::IDX_ENERGY_CTRL, {8'h00, lpi_tab[i][15:8]});
      repeat (2) @(posedge clk);
      #1 `CHK({tx_lpi, rx_lpi}, lpi_tab[i][4:3])
    end
    wr(tfg_pkg::IDX_PAGE_ACCESS, tfg_pkg::PAGE_MAIN);
    rc(tfg_pkg::IDX_ENERGY_CTRL, 16'h0000);
    rc(tfg_pkg::IDX_GEN_PATTERN, 16'h0000);
    // MAC stream reaches the line while the generator is off
    mac_tx <= '{valid: 1'b1, data: 8'h3c, last: 1'b1};
    @(posedge clk);
    mac_tx <= '0;
    #1 `CHK(line_tx, 10'h279)
    // Every length code, fixed payload, short gap
    foreach (len_tab[c])
    begin
      gen_run(16'he258 | (16'(c) << 11));
      `CHK(14'(lp.last_len), len_tab[c])
      `CHK({lp.frame[5], lp.frame[11], lp.frame[20]}, 24'hf9_f65a)
      `CHK(lp.last_gap, 12)
      `CHK(fcs_at(len_tab[c]), ~frame_crc(len_tab[c] - 4))
    end
    gen_run(16'he258 | 16'h0801);
    `CHK(fcs_at(64), frame_crc(60))
    gen_run(16'he258 | 16'h0802);
    `CHK({lp.frame[20], lp.frame[21], lp.frame[22]} == 24'h5a_5a5a, 1'b0)
    gen_run(16'he258 | 16'h0c00);
    `CHK(lp.last_gap, 1024)
    // Clearing run mid-stream in continuous mode must not stop before the packet count is a multiple
    gen_run(16'he258 | 16'h0800);
    wr(tfg_pkg::IDX_GEN_CONTROL, 16'ha258 | 16'h0800);
    n = lp.frames;
    repeat (400) @(posedge clk);
    `CHK(lp.frames > n + 3, 1'b1)
    `CHK(busy || line_tx.valid, 1'b1)
    wrap_up();
  end
endmodule // tfg_ext_page_ctrl_bench
